//--- rtl/mfr_pkg.sv
// constants, register map and carrier types for the motor fault response block
// assumes a single 25 MHz clock and a plain strobe-based register port
package mfr_pkg;
   localparam int unsigned ADDR_W      = 4;
   localparam int unsigned DATA_W      = 16;
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h1;
   localparam logic [3:0]  REG_DIAG    = 4'h2;
   // control register fields
   localparam int unsigned CTRL_RUN     = 0;
   localparam int unsigned CTRL_RESTART = 1;
   localparam int unsigned CTRL_DSR     = 2;
   localparam int unsigned CTRL_STOP_ON_FAULT = 3;
   localparam logic [3:0]  CTRL_RESET   = 4'h0;
   // status register fields
   localparam int unsigned STS_SYS    = 0;
   localparam int unsigned STS_SERIAL = 1;
   localparam int unsigned STS_UV     = 2;
   localparam int unsigned STS_BOOT   = 3;
   localparam int unsigned STS_SYNC   = 4;
   localparam int unsigned STS_DS     = 5;
   localparam int unsigned STS_OT     = 6;
   localparam int unsigned STS_BLOCK  = 7;
   localparam int unsigned STS_OUTEN  = 8;
   // overtemperature release delay
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned OT_HOLD_MS  = 10;
   localparam int unsigned OT_HOLD_CYC = OT_HOLD_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic       sys_err;
      logic       serial_err;
      logic       supply_por;
      logic       supply_uv;
      logic       gate_uv;
      logic [2:0] boot_uv;
      logic       temp_warn;
      logic       over_temp;
      logic       sync_loss;
      logic [5:0] ds_ov;
   } mfr_fault_t;
endpackage

//--- rtl/mfr_hold_timer.sv
// hold timer: counts cycles while enabled, pulses done on the last one
// assumes enable stays high for the whole wait; dropping it restarts the count
`timescale 1ns/100ps
module mfr_hold_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic enable,
   output logic      done
);
   logic [31:0] cnt_r;

   // count up while enabled, restart on any gap
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         cnt_r <= 32'h0;
      else if (!enable || done)
         cnt_r <= 32'h0;
      else
         cnt_r <= cnt_r + 32'h1;
   end

   assign done = enable && (cnt_r == CYCLES - 1);
endmodule

//--- rtl/mfr_fault_resp.sv
// fault response manager: decides gate shutdown, latching and release
// assumes fault inputs and demand are synchronous to mclk
//
// Function
// R1 - every listed fault except serial error and temp warning turns all outputs off (code: bootstrap and drain-source only mask gates with stop-on-fault)
// R2 - all-off means every one of the six gate outputs driven low together
// R3 - per-transistor faults drive low only that gate, others stay normal
// R4 - latch uv, bootstrap, sync loss, drain-source; clear on zero demand or run low (code: uv not latched with restart select)
// R5 - status or diagnostic read clears latched state only while dsr disable is 0
// R6 - after latch, outputs return only after demand goes zero then nonzero
// R7 - after latch, run cleared then set also re-enables outputs
// R8 - overtemp: outputs off, latch, regulator off, host reset; clear 10 ms later
// R9 - with restart select, sync loss is not latched, restart requested instead
`timescale 1ns/100ps
module mfr_fault_resp #(
   parameter int unsigned OT_HOLD_CYCLES = mfr_pkg::OT_HOLD_CYC
) (
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   input  wire mfr_pkg::mfr_fault_t        flt,
   input  wire logic [7:0]                 demand,
   input  wire logic [5:0]                 gate_cmd,
   input  wire logic [mfr_pkg::ADDR_W-1:0] bus_addr,
   input  wire logic [mfr_pkg::DATA_W-1:0] bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [mfr_pkg::DATA_W-1:0] bus_rdata,
   output logic      [5:0]                 gate_out,
   output logic                            host_reset_out_n,
   output logic                            logic_supply_regulator_en,
   output logic                            restart_req
);
   logic [3:0] ctrl_r;
   logic       sys_lat_r, ser_lat_r, uv_lat_r, boot_lat_r, sync_lat_r, ds_lat_r, ot_lat_r;
   logic       block_r, seen_zero_r, sync_prev_r;
   logic       run, auto_restart_select, dsr, stop_on_fault_enable;
   logic       ser_reset, lat_clr, demand_zero, any_set, all_off, ot_done;
   logic [5:0] per_off;
   logic       uv_set, boot_set, sync_set, ds_set;

   assign run                  = ctrl_r[mfr_pkg::CTRL_RUN];
   assign auto_restart_select  = ctrl_r[mfr_pkg::CTRL_RESTART];
   assign dsr                  = ctrl_r[mfr_pkg::CTRL_DSR];
   assign stop_on_fault_enable = ctrl_r[mfr_pkg::CTRL_STOP_ON_FAULT];
   assign demand_zero = (demand == 8'h00);

   // a status or diagnostic read resets fault state unless disabled
   assign ser_reset = bus_rd && !dsr && ((bus_addr == mfr_pkg::REG_STATUS) ||
                      (bus_addr == mfr_pkg::REG_DIAG)); // R5
   assign lat_clr   = demand_zero || !run || ser_reset; // R4

   // latch conditions; with stop-on-fault set, bridge faults act per transistor
   assign uv_set   = flt.supply_uv && !auto_restart_select;
   assign boot_set = (flt.boot_uv != 3'h0) && !stop_on_fault_enable;
   assign sync_set = flt.sync_loss && !auto_restart_select; // R9
   assign ds_set   = (flt.ds_ov != 6'h00) && !stop_on_fault_enable;
   assign any_set  = uv_set || boot_set || sync_set || ds_set || flt.over_temp || flt.sys_err;

   // control register; a system error forces run low, set beats software
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_r <= mfr_pkg::CTRL_RESET;
      else
      begin
         if (bus_wr && bus_addr == mfr_pkg::REG_CTRL)
            ctrl_r <= bus_wdata[3:0];
         if (flt.sys_err)
            ctrl_r[mfr_pkg::CTRL_RUN] <= 1'b0;
      end
   end

   // fault state latches: a new fault in the clearing cycle is kept
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         uv_lat_r   <= 1'b0;
         boot_lat_r <= 1'b0;
         sync_lat_r <= 1'b0;
         ds_lat_r   <= 1'b0;
      end
      else
      begin
         uv_lat_r   <= uv_set   || (uv_lat_r   && !lat_clr); // R4
         boot_lat_r <= boot_set || (boot_lat_r && !lat_clr); // R4
         sync_lat_r <= sync_set || (sync_lat_r && !lat_clr); // R4
         ds_lat_r   <= ds_set   || (ds_lat_r   && !lat_clr); // R4
      end
   end

   // system error clears on a write of run high; serial error on a read
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sys_lat_r <= 1'b0;
         ser_lat_r <= 1'b0;
      end
      else
      begin
         sys_lat_r <= flt.sys_err || (sys_lat_r && !(bus_wr && bus_addr == mfr_pkg::REG_CTRL &&
                      bus_wdata[mfr_pkg::CTRL_RUN]));
         ser_lat_r <= flt.serial_err || (ser_lat_r && !ser_reset); // R5
      end
   end

   // overtemperature holds until the hold timer expires after removal
   mfr_hold_timer #(
      .CYCLES (OT_HOLD_CYCLES)
   ) u_ot_timer (
      .mclk    (mclk),
      .reset_n (reset_n),
      .enable  (ot_lat_r && !flt.over_temp),
      .done    (ot_done)
   );

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ot_lat_r <= 1'b0;
      else if (flt.over_temp)
         ot_lat_r <= 1'b1; // R8
      else if (ot_done)
         ot_lat_r <= 1'b0; // R8
   end

   // re-enable gate: a uv, bootstrap, sync or drain-source latch blocks until demand or run has passed through zero
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         block_r     <= 1'b0;
         seen_zero_r <= 1'b0;
      end
      else if (any_set && !flt.over_temp && !flt.sys_err)
      begin
         block_r     <= 1'b1;
         seen_zero_r <= 1'b0;
      end
      else if (block_r)
      begin
         if (demand_zero || !run)
            seen_zero_r <= 1'b1; // R6 R7
         else if (seen_zero_r)
            block_r <= 1'b0; // R6 R7
      end
   end

   // one-cycle restart request on each fresh loss of sync in restart mode
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         sync_prev_r <= 1'b0;
      else
         sync_prev_r <= flt.sync_loss;
   end
   assign restart_req = auto_restart_select && flt.sync_loss && !sync_prev_r; // R9

   // shutdown decision; serial error and temp warning never stop the bridge
   assign all_off = !run || sys_lat_r || flt.sys_err || flt.supply_por || flt.gate_uv ||
                    flt.supply_uv || uv_lat_r || boot_lat_r || boot_set || sync_lat_r ||
                    flt.sync_loss || ds_lat_r || ds_set || ot_lat_r || flt.over_temp ||
                    block_r; // R1
   assign per_off = stop_on_fault_enable ? (flt.ds_ov | {3'h0, flt.boot_uv}) : 6'h00; // R3

   // gate outputs registered so all six drop on the same edge
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         gate_out <= 6'h00;
      else if (all_off)
         gate_out <= 6'h00; // R2
      else
         gate_out <= gate_cmd & ~per_off; // R3
   end

   // regulator and host reset follow the overtemperature latch
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         host_reset_out_n          <= 1'b0;
         logic_supply_regulator_en <= 1'b0;
      end
      else
      begin
         host_reset_out_n          <= !(ot_lat_r || flt.over_temp); // R8
         logic_supply_regulator_en <= !(ot_lat_r || flt.over_temp); // R8
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         bus_rdata <= 16'h0000;
      else if (bus_rd)
      begin
         bus_rdata <= 16'h0000;
         case (bus_addr)
            mfr_pkg::REG_CTRL:   bus_rdata[3:0] <= ctrl_r;
            mfr_pkg::REG_STATUS:
            begin
               bus_rdata[mfr_pkg::STS_SYS]    <= sys_lat_r;
               bus_rdata[mfr_pkg::STS_SERIAL] <= ser_lat_r;
               bus_rdata[mfr_pkg::STS_UV]     <= uv_lat_r;
               bus_rdata[mfr_pkg::STS_BOOT]   <= boot_lat_r;
               bus_rdata[mfr_pkg::STS_SYNC]   <= sync_lat_r;
               bus_rdata[mfr_pkg::STS_DS]     <= ds_lat_r;
               bus_rdata[mfr_pkg::STS_OT]     <= ot_lat_r;
               bus_rdata[mfr_pkg::STS_BLOCK]  <= block_r;
               bus_rdata[mfr_pkg::STS_OUTEN]  <= !all_off;
            end
            mfr_pkg::REG_DIAG:   bus_rdata <= flt[15:0];
            default:             bus_rdata <= 16'h0000;
         endcase
      end
      else
         bus_rdata <= 16'h0000;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_all_off;
      all_off |=> (gate_out == 6'h00);
   endproperty
   a_all_off: assert property (p_all_off) else $error("gates not all low on fault"); // R1

   property p_per_gate;
      !all_off |=> (gate_out == ($past(gate_cmd) & ~$past(per_off)));
   endproperty
   a_per_gate: assert property (p_per_gate) else $error("per-gate drive wrong"); // R3

   property p_ds_latch;
      ds_set ##1 (!ds_set && !lat_clr) |=> ds_lat_r;
   endproperty
   a_ds_latch: assert property (p_ds_latch) else $error("drain-source fault not held"); // R4

   property p_boot_clear;
      (lat_clr && !boot_set) |=> !boot_lat_r;
   endproperty
   a_boot_clear: assert property (p_boot_clear) else $error("bootstrap latch not cleared"); // R4

   property p_ser_clear;
      (ser_reset && !flt.serial_err) |=> !ser_lat_r;
   endproperty
   a_ser_clear: assert property (p_ser_clear) else $error("serial read did not clear"); // R5

   property p_dsr_hold;
      (dsr && bus_rd && run && !demand_zero && boot_lat_r) |=> boot_lat_r;
   endproperty
   a_dsr_hold: assert property (p_dsr_hold) else $error("read cleared with dsr set"); // R5

   property p_block_hold;
      (block_r && !seen_zero_r && !demand_zero && run) |=> block_r ##1 (gate_out == 6'h00);
   endproperty
   a_block_hold: assert property (p_block_hold) else $error("outputs back without sequence"); // R6

   property p_run_seq;
      (block_r && !run && !any_set) |=> seen_zero_r;
   endproperty
   a_run_seq: assert property (p_run_seq) else $error("run low not recorded"); // R7

   property p_ot;
      flt.over_temp |=> (!host_reset_out_n && !logic_supply_regulator_en && ot_lat_r);
   endproperty
   a_ot: assert property (p_ot) else $error("overtemp actions missing"); // R8

   property p_sync_restart;
      (auto_restart_select && flt.sync_loss && !sync_prev_r && !sync_lat_r) |->
         restart_req ##1 !sync_lat_r;
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("restart mode misbehaved"); // R9
endmodule

//--- test/mfr_host_model.sv
// host model: master side of the fault block register port
// assumes strobes are sampled on rising mclk and read data stand one cycle
`timescale 1ns/100ps
module mfr_host_model (
   input  wire logic                       mclk,
   output logic      [mfr_pkg::ADDR_W-1:0] bus_addr,
   output logic      [mfr_pkg::DATA_W-1:0] bus_wdata,
   output logic                            bus_wr,
   output logic                            bus_rd,
   input  wire logic [mfr_pkg::DATA_W-1:0] bus_rdata
);
   // idle bus from time zero
   initial
   begin
      bus_addr  = 4'h0;
      bus_wdata = 16'h0000;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
   end

   // one-cycle write strobe; run reset is two of these in a row
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge mclk);
      bus_wr    <= 1'b0;
   endtask

   // read data only stand in the cycle after the strobe, so take them there
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge mclk);
      bus_rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the fault response block
// assumes the host model owns the register port; release timer shortened
`timescale 1ns/100ps
module testbench;
   localparam int unsigned HOLD = 8;
   logic                mclk;
   logic                reset_n;
   mfr_pkg::mfr_fault_t flt;
   logic [7:0]          demand;
   logic [5:0]          gate_cmd;
   logic [5:0]          gate_out;
   logic [3:0]          bus_addr;
   logic [15:0]         bus_wdata;
   logic [15:0]         bus_rdata;
   logic [15:0]         rv;
   logic                bus_wr;
   logic                bus_rd;
   logic                host_reset_out_n;
   logic                reg_en;
   logic                restart_req;
   logic [31:0]         lfsr_r;
   logic [3:0]          ctrl_v;
   mfr_pkg::mfr_fault_t exp_f;
   int                  fail_count;
   int                  checks_done;
   int                  i;
   int                  n;

   mfr_fault_resp #(.OT_HOLD_CYCLES(HOLD)) mfr_fault_resp_i (.mclk(mclk), .reset_n(reset_n),
      .flt(flt), .demand(demand), .gate_cmd(gate_cmd), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .gate_out(gate_out), .host_reset_out_n(host_reset_out_n),
      .logic_supply_regulator_en(reg_en), .restart_req(restart_req));
   mfr_host_model mfr_host_model_i (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   // 25 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // gates expected from the fault situation: all off, or some bits masked
   function automatic logic [5:0] exp_gate(input logic [5:0] c, input logic off,
                                           input logic [5:0] m);
      return off ? 6'h00 : (c & ~m);
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // wait n edges and let their updates land before looking
   task automatic look(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   // remove faults, cycle demand through zero so no latch but the serial error one survives
   task automatic recover();
      @(posedge mclk);
      flt    <= '0;
      demand <= 8'h00;
      look(3);
      mfr_host_model_i.wr(mfr_pkg::REG_CTRL, {12'h000, ctrl_v});
      lfsr_r = lfsr_next(lfsr_r);
      demand   <= {lfsr_r[7:1], 1'b1};
      gate_cmd <= lfsr_r[13:8];
      look(5);
   endtask

   // built aside, then applied by nba so the design never races the edge
   task automatic set_fault(input int k);
      mfr_pkg::mfr_fault_t f;
      f = '0;
      case (k)
         0: f.sys_err = 1'b1;
         1: f.serial_err = 1'b1;
         2: f.supply_por = 1'b1;
         3: f.supply_uv = 1'b1;
         4: f.gate_uv = 1'b1;
         5: f.boot_uv = 3'h2;
         6: f.temp_warn = 1'b1;
         7: f.sync_loss = 1'b1;
         default: f.ds_ov = 6'h20;
      endcase
      flt <= f;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog far beyond the expected run length
   initial
   begin
      #(40 * 20000);
      fail_count++;
      report_and_stop();
   end

   initial
   begin
      fail_count  = 0;
      checks_done = 0;
      lfsr_r      = 32'h3a0f;
      flt         = '0;
      demand      = 8'h00;
      gate_cmd    = 6'h00;
      reset_n     = 1'b0;
      ctrl_v      = 4'h1;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      look(2);
      chk("host_reset", 16'h1, {15'h0, host_reset_out_n});
      recover();
      // random command traffic with no fault present
      for (i = 0; i < 20; i++)
      begin
         @(posedge mclk);
         lfsr_r = lfsr_next(lfsr_r);
         gate_cmd <= lfsr_r[5:0];
         look(2);
         chk("gate_free", {10'h0, exp_gate(gate_cmd, 1'b0, 6'h00)}, {10'h0, gate_out});
      end
      $display("test free running done");
      // every listed fault except overtemp; only serial error and warning leave gates alone
      for (i = 0; i < 9; i++)
      begin
         @(posedge mclk);
         set_fault(i);
         look(3);
         chk("gate_fault", {10'h0, exp_gate(gate_cmd, !(i == 1 || i == 6), 6'h00)},
             {10'h0, gate_out});
         recover();
         chk("gate_back", {10'h0, gate_cmd}, {10'h0, gate_out});
      end
      $display("test fault table done");
      // short drain-source glitch must stay latched until demand cycles through zero
      @(posedge mclk);
      flt.ds_ov <= 6'h01;
      @(posedge mclk);
      flt <= '0;
      look(4);
      chk("gate_latched", 16'h0, {10'h0, gate_out});
      @(posedge mclk);
      demand <= 8'h00;
      look(3);
      @(posedge mclk);
      demand <= 8'h40;
      look(4);
      chk("gate_demand", {10'h0, gate_cmd}, {10'h0, gate_out});
      // sync loss glitch released by run cleared then set
      @(posedge mclk);
      flt.sync_loss <= 1'b1;
      @(posedge mclk);
      flt <= '0;
      look(4);
      chk("gate_sync", 16'h0, {10'h0, gate_out});
      mfr_host_model_i.wr(mfr_pkg::REG_CTRL, 16'h0000);
      mfr_host_model_i.wr(mfr_pkg::REG_CTRL, 16'h0001);
      look(4);
      chk("gate_run", {10'h0, gate_cmd}, {10'h0, gate_out});
      $display("test release paths done");
      // status read clears a latch only while the read-reset disable is 0
      for (n = 0; n < 2; n++)
      begin
         ctrl_v = (n == 0) ? 4'h1 : 4'h5;
         recover();
         @(posedge mclk);
         flt.boot_uv <= 3'h1;
         look(2);
         mfr_host_model_i.rd(mfr_pkg::REG_DIAG, rv);
         exp_f         = '0;
         exp_f.boot_uv = 3'h1;
         chk("diag", exp_f[15:0], rv);
         @(posedge mclk);
         flt <= '0;
         look(2);
         mfr_host_model_i.rd(mfr_pkg::REG_STATUS, rv);
         chk("boot_first", 16'h1, {15'h0, rv[mfr_pkg::STS_BOOT]});
         mfr_host_model_i.rd(mfr_pkg::REG_STATUS, rv);
         chk("boot_second", {15'h0, n == 1}, {15'h0, rv[mfr_pkg::STS_BOOT]});
      end
      // stop-on-fault: only the affected gates drop
      ctrl_v = 4'h9;
      recover();
      // all gates commanded on, so each masked bit is really seen to drop
      @(posedge mclk);
      gate_cmd    <= 6'h3f;
      flt.ds_ov   <= 6'h04;
      flt.boot_uv <= 3'h1;
      look(3);
      chk("gate_one", {10'h0, exp_gate(6'h3f, 1'b0, 6'h05)}, {10'h0, gate_out});
      // overtemperature holds host in reset until the hold time after removal
      ctrl_v = 4'h1;
      recover();
      @(posedge mclk);
      flt.over_temp <= 1'b1;
      look(3);
      chk("ot_on", 16'h0, {8'h0, gate_out, host_reset_out_n, reg_en});
      @(posedge mclk);
      flt <= '0;
      look(4);
      chk("ot_hold", 16'h0, {15'h0, host_reset_out_n});
      // host still held through the last counted cycle, released one later
      look(HOLD - 4);
      chk("ot_last", 16'h0, {15'h0, host_reset_out_n});
      look(1);
      chk("ot_free", 16'h3, {14'h0, host_reset_out_n, reg_en});
      // auto restart: sync loss not latched, one restart pulse
      ctrl_v = 4'h3;
      recover();
      @(posedge mclk);
      flt.sync_loss <= 1'b1;
      n = 0;
      for (i = 0; i < 4; i++)
      begin
         #1 n += restart_req;
         @(posedge mclk);
      end
      chk("restart", 16'h1, n[15:0]);
      flt <= '0;
      look(4);
      chk("gate_restart", {10'h0, gate_cmd}, {10'h0, gate_out});
      $display("test special faults done");
      report_and_stop();
   end
endmodule
